/* File: logic/dac_spi_register_port.sv */
`timescale 1ns/1ps
`default_nettype none

module dac_spi_register_port (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // Serial pins, asynchronous to core_clk
  input  wire logic                       sclk,
  input  wire logic                       csN,
  input  wire logic                       sdioIn,
  output logic                            sdioOut,
  output logic                            sdioOeN,
  output logic                            sdoOut,
  output logic                            sdoOeN,
  // Register contents towards the device core
  output logic [127:0][7:0]               regImage,
  output dac_spi_pkg::cfg_t               portCfg,
  output dac_spi_pkg::wr_t                regWrite
);

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  logic [2:0] sclkPipe;      // Two-stage sync plus edge history
  logic [1:0] csPipe;        // Two-stage sync of chip select
  logic [1:0] sdiPipe;       // Two-stage sync of serial data

  // All pins share the same latency, so data stays aligned with its edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkPipe <= 3'h0;
      csPipe   <= 2'h3;
      sdiPipe  <= 2'h0;
    end else begin
      sclkPipe <= {sclkPipe[1:0], sclk};
      csPipe   <= {csPipe[0], csN};
      sdiPipe  <= {sdiPipe[0], sdioIn};
    end
  end

  // Only the second and third stages are looked at
  wire sclkRise  = sclkPipe[1] & ~sclkPipe[2];
  wire sclkFall  = ~sclkPipe[1] & sclkPipe[2];
  wire csActive  = ~csPipe[1];
  wire sdiBit    = sdiPipe[1];

  // ========================================================================
  // State and decode
  // ========================================================================
  dac_spi_pkg::phase_t phaseQ, phaseD;   // Instruction or data phase
  logic [2:0]          bitCntQ, bitCntD; // Bit position within a byte
  logic [7:0]          rxSrQ, rxSrD;     // Receive shifter
  dac_spi_pkg::instr_t instrQ, instrD;   // Captured instruction
  logic [7:0]          txSrQ;            // Readback shifter
  logic                txEnQ;            // Output driver enabled
  logic [4:0]          zeroRunQ;         // Consecutive zero bits seen
  logic [7:0]          memQ [128];       // Register array
  dac_spi_pkg::wr_t    wrQ;              // Registered write notice

  // Current configuration steers the shifters and the pins
  wire [7:0] cfgRaw   = memQ[dac_spi_pkg::CFG_ADDR];
  wire       lsbFirst = cfgRaw[dac_spi_pkg::CFG_LSB_BIT];
  wire       bidir    = cfgRaw[dac_spi_pkg::CFG_BIDIR_BIT];

  // Sample on the rising serial edge while selected
  wire stepRise = sclkRise & csActive;

  // Next receive byte in the chosen bit order
  wire [7:0] rxNext = lsbFirst ? {sdiBit, rxSrQ[7:1]}
                               : {rxSrQ[6:0], sdiBit};

  // A long run of zeros pulls the port back to a known state
  wire recoverHit = stepRise & ~sdiBit
                  & (zeroRunQ == dac_spi_pkg::RECOVER_ZEROS - 5'h01);

  // Byte completion, split by phase
  wire byteDone  = stepRise & (bitCntQ == dac_spi_pkg::LAST_BIT);
  wire instrDone = byteDone & (phaseQ == dac_spi_pkg::PH_INSTR) & ~recoverHit;
  wire dataDone  = byteDone & (phaseQ == dac_spi_pkg::PH_DATA) & ~recoverHit;

  // Write takes effect on the edge that completes the data byte
  wire                      wrEn   = dataDone & ~instrQ.read;
  wire [6:0]                wrAddr = instrQ.addr;
  wire                      restorePulse = wrEn & (wrAddr == dac_spi_pkg::CFG_ADDR)
                                         & rxNext[dac_spi_pkg::CFG_RESTORE_BIT];
  // The restore bit never sticks, so the stored configuration always holds it at zero
  wire [7:0]                cfgWrData = rxNext & ~dac_spi_pkg::CFG_RESTORE_MASK;

  // Address of a read taken from the instruction just completed
  wire dac_spi_pkg::instr_t rxInstr = dac_spi_pkg::instr_t'(rxNext);
  wire                      readStart = instrDone & rxInstr.read;

  // ========================================================================
  // Phase sequencing
  // ========================================================================
  always_comb begin
    phaseD  = phaseQ;
    bitCntD = bitCntQ;
    rxSrD   = rxSrQ;
    instrD  = instrQ;
    if (recoverHit) begin
      // Realign on the byte that follows the zero run
      phaseD  = dac_spi_pkg::PH_INSTR;
      bitCntD = 3'h0;
    end else if (!csActive) begin
      // Deselect on a byte boundary keeps everything; mid-byte throws it away
      if (bitCntQ != 3'h0) begin
        phaseD  = dac_spi_pkg::PH_INSTR;
        bitCntD = 3'h0;
      end
    end else if (stepRise) begin
      rxSrD   = rxNext;
      bitCntD = bitCntQ + 3'h1;
      if (bitCntQ == dac_spi_pkg::LAST_BIT) begin
        unique case (phaseQ)
          dac_spi_pkg::PH_INSTR: begin
            instrD = rxInstr;
            phaseD = dac_spi_pkg::PH_DATA;
          end
          dac_spi_pkg::PH_DATA: begin
            // One byte only: the next byte is a new instruction
            phaseD = dac_spi_pkg::PH_INSTR;
          end
          default: begin
            phaseD = dac_spi_pkg::PH_INSTR;
          end
        endcase
      end
    end
  end

  // Phase registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseQ  <= dac_spi_pkg::PH_INSTR;
      bitCntQ <= 3'h0;
      rxSrQ   <= 8'h00;
      instrQ  <= '0;
    end else begin
      phaseQ  <= phaseD;
      bitCntQ <= bitCntD;
      rxSrQ   <= rxSrD;
      instrQ  <= instrD;
    end
  end

  // Zero run counter, kept across deselects so a split sequence still counts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      zeroRunQ <= 5'h00;
    end else if (stepRise) begin
      if (sdiBit) begin
        zeroRunQ <= 5'h00;
      end else if (zeroRunQ != dac_spi_pkg::ZERO_RUN_MAX) begin
        zeroRunQ <= zeroRunQ + 5'h01;
      end
    end
  end

  // ========================================================================
  // Register array
  // ========================================================================
  for (genvar i = 0; i < dac_spi_pkg::NUM_REGS; i++) begin : g_reg
    if (i == 0) begin : g_cfg
      // Configuration: recovery wins over a write in the same cycle
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          memQ[i] <= dac_spi_pkg::CFG_RESET;
        end else if (recoverHit) begin
          memQ[i] <= dac_spi_pkg::RECOVER_CFG;
        end else if (wrEn && wrAddr == dac_spi_pkg::CFG_ADDR) begin
          memQ[i] <= cfgWrData;
        end
      end
    end else begin : g_gen
      // Ordinary register: restore to default, else take a write
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          memQ[i] <= dac_spi_pkg::REG_RESET;
        end else if (restorePulse) begin
          memQ[i] <= dac_spi_pkg::REG_RESET;
        end else if (wrEn && wrAddr == 7'(i)) begin
          memQ[i] <= rxNext;
        end
      end
    end
    assign regImage[i] = memQ[i];
  end

  // Write notice for the device core, registered on the same edge as the array update
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrQ <= '0;
    end else begin
      wrQ.en   <= wrEn;
      wrQ.addr <= wrAddr;
      wrQ.data <= rxNext;
    end
  end

  // ========================================================================
  // Readback path
  // ========================================================================
  // Load the addressed byte as the instruction completes, shift on each rise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txSrQ <= 8'h00;
    end else if (readStart) begin
      txSrQ <= memQ[rxInstr.addr];
    end else if (stepRise && txEnQ) begin
      txSrQ <= lsbFirst ? {1'b0, txSrQ[7:1]} : {txSrQ[6:0], 1'b0};
    end
  end

  // Driver turns on at the falling edge after the instruction, which
  // gives the master's driver half a serial period to let go
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txEnQ <= 1'b0;
    end else if (!csActive || phaseQ != dac_spi_pkg::PH_DATA || recoverHit) begin
      txEnQ <= 1'b0;
    end else if (sclkFall && instrQ.read) begin
      txEnQ <= 1'b1;
    end
  end

  // Pin selection: shared pin or dedicated output, never both
  wire txBit = lsbFirst ? txSrQ[0] : txSrQ[7];
  assign sdioOut  = txBit;
  assign sdoOut   = txBit;
  assign sdioOeN  = ~(txEnQ & csActive & bidir);
  assign sdoOeN   = ~(txEnQ & csActive & ~bidir);
  assign portCfg  = dac_spi_pkg::cfg_t'(cfgRaw);
  assign regWrite = wrQ;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_instrByte;
    byteDone && phaseQ == dac_spi_pkg::PH_INSTR && !recoverHit;
  endsequence

  sequence s_dataByte;
    byteDone && phaseQ == dac_spi_pkg::PH_DATA && !recoverHit;
  endsequence

  a_instr_to_data: assert property (s_instrByte |=> phaseQ == dac_spi_pkg::PH_DATA)
    else $error("instruction byte did not open the data phase");

  a_write_lands: assert property ((s_dataByte ##0 (!instrQ.read && instrQ.addr != 7'h00))
      |=> memQ[$past(instrQ.addr)] == $past(rxNext))
    else $error("write data not stored at the addressed register");

  a_read_keeps: assert property ((s_dataByte ##0 instrQ.read && !recoverHit)
      |=> regImage == $past(regImage))
    else $error("read cycle changed a register");

  a_single_byte: assert property (s_dataByte |=> phaseQ == dac_spi_pkg::PH_INSTR
      ##1 (phaseQ == dac_spi_pkg::PH_INSTR || stepRise))
    else $error("data phase did not end after one byte");

  a_abort_partial: assert property ((!csActive && bitCntQ != 3'h0)
      |=> bitCntQ == 3'h0 && phaseQ == dac_spi_pkg::PH_INSTR)
    else $error("partial byte not abandoned on deselect");

  a_stall_holds: assert property ((!csActive && bitCntQ == 3'h0)
      |=> $stable(phaseQ) && $stable(instrQ))
    else $error("stall on a byte boundary lost state");

  a_idle_release: assert property (!csActive |-> (sdioOeN && sdoOeN) ##1 !txEnQ)
    else $error("output driven while deselected");

  a_pin_select: assert property (csActive && !bidir |-> sdioOeN)
    else $error("shared pin driven in separate-pin mode");

  a_lsb_order: assert property ((stepRise && lsbFirst && !recoverHit)
      |=> rxSrQ[7] == $past(sdiBit))
    else $error("LSB-first bit not placed at the top");

  a_recover_cfg: assert property (recoverHit
      |=> memQ[0] == dac_spi_pkg::RECOVER_CFG && bitCntQ == 3'h0)
    else $error("zero run did not restore the port");

  a_restore_defaults: assert property (restorePulse
      |=> memQ[1] == dac_spi_pkg::REG_RESET && !memQ[0][dac_spi_pkg::CFG_RESTORE_BIT])
    else $error("default restore incomplete");

  a_read_turn: assert property ((csActive && sclkFall && phaseQ == dac_spi_pkg::PH_DATA
      && instrQ.read && !recoverHit) |=> txEnQ)
    else $error("readback driver not enabled after falling edge");

endmodule : dac_spi_register_port
`default_nettype wire

/* File: pkg/dac_spi_pkg.sv */
`default_nettype none
// ==========================================================================
// Serial register port constants and types
// ==========================================================================
package dac_spi_pkg;

  // Register space
  localparam int         ADDR_W   = 7;             // Instruction address width
  localparam int         DATA_W   = 8;             // One data byte per cycle
  localparam int         NUM_REGS = 128;           // Full 7-bit address space
  localparam logic [6:0] CFG_ADDR = 7'h00;         // Port configuration register

  // Instruction byte layout
  localparam int INSTR_READ_BIT = 7;               // One selects a read

  // Configuration register fields
  localparam int         CFG_BIDIR_BIT   = 7;      // One: shared data pin
  localparam int         CFG_LSB_BIT     = 6;      // One: least significant bit first
  localparam int         CFG_RESTORE_BIT = 5;      // Self-clearing default restore
  localparam logic [7:0] CFG_RESTORE_MASK = 8'h20; // Mask of the restore bit

  // Reset values
  localparam logic [7:0] CFG_RESET   = 8'h80;      // Shared pin, MSB first
  localparam logic [7:0] REG_RESET   = 8'h00;      // Every other register
  localparam logic [7:0] RECOVER_CFG = 8'h00;      // Config after recovery

  // Serial framing
  localparam logic [2:0] LAST_BIT      = 3'h7;     // Eighth bit of a byte
  localparam logic [4:0] RECOVER_ZEROS = 5'h19;    // Partial zeros plus three 0x00 bytes
  localparam logic [4:0] ZERO_RUN_MAX  = 5'h1f;    // Saturation of the zero counter

  // Timing: the serial clock is oversampled by the core clock
  localparam int SCLK_MAX_KHZ = 20000;             // Fastest serial clock
  localparam int CORE_KHZ     = 100000;            // Core clock rate
  localparam int SCLK_MIN_CYC = CORE_KHZ / SCLK_MAX_KHZ; // Core cycles per serial period

  // Serial phase, one-hot
  typedef enum logic [1:0] {
    PH_INSTR = 2'b01,
    PH_DATA  = 2'b10
  } phase_t;

  // Captured instruction byte
  typedef struct packed {
    logic             read;
    logic [ADDR_W-1:0] addr;
  } instr_t;

  // Configuration register view
  typedef struct packed {
    logic       sdioBidir;
    logic       lsbFirst;
    logic       restore;
    logic [4:0] spare;
  } cfg_t;

  // Register write notification towards the device core
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_t;

endpackage : dac_spi_pkg
`default_nettype wire

/* File: test/link_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial master model: drives the link, resolves both data lines
// ==========================================================
module link_master (
  // Clock
  input  wire logic core_clk,
  // Link pins
  output logic      sclk,
  output logic      csN,
  output logic      sdioLine,
  output logic      sdoLine,
  // Device drivers
  input  wire logic sdioOut,
  input  wire logic sdioOeN,
  input  wire logic sdoOut,
  input  wire logic sdoOeN
);
  logic mDrv;   // Master data bit
  logic mEn;    // Master owns the shared pin
  logic junkQ;  // Noise on an undriven line

  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    mDrv = 1'b0;
    mEn  = 1'b1;
  end

  // Toggle every cycle so a released line never repeats its last value
  always @(posedge core_clk) begin
    junkQ <= (junkQ === 1'b1) ? 1'b0 : 1'b1;
  end

  // Wire levels from every party's enable
  assign sdioLine = !sdioOeN ? sdioOut : (mEn ? mDrv : junkQ);
  assign sdoLine  = !sdoOeN ? sdoOut : junkQ;

  // Wait n core edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Chip select change, link clock stands low around it
  task automatic sel(input logic lvl);
    tick(8);
    csN = lvl;
    mEn = 1'b1;
    tick(8);
  endtask : sel

  // Shift n bits at a 160 ns link period, data set while sclk is low
  task automatic shift(input int n, input logic [7:0] v, input logic lsb,
                       input logic rd, input logic sdo, output logic [7:0] got);
    int k;
    got = 8'h00;
    mEn = !rd;  // Released before readback
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : 7 - i;  // Bit order
      mDrv = v[k];
      tick(8);
      got[k] = sdo ? sdoLine : sdioLine;  // Sampled before the rise
      sclk = 1'b1;
      tick(8);
      sclk = 1'b0;
    end
  endtask : shift
endmodule : link_master
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the serial register port
// ==========================================================
module tb;
  logic                  core_clk;    // 100 MHz core clock
  logic                  rst_n;       // Async reset
  logic                  sclk;        // Link clock
  logic                  csN;         // Chip select
  logic                  sdioLine;    // Shared pin level
  logic                  sdoLine;     // Output pin level
  logic                  sdioOut;     // Device shared-pin bit
  logic                  sdioOeN;     // Device shared-pin enable
  logic                  sdoOut;      // Device output-pin bit
  logic                  sdoOeN;      // Device output-pin enable
  logic [127:0][7:0]     regImage;    // Register contents
  dac_spi_pkg::cfg_t     portCfg;     // Register 0 view
  logic [7:0]            got;         // Last shifted-in byte
  int                    mismatches;  // Failed comparisons
  int                    nCompared;   // All comparisons
  int                    nWrites = 0; // Write notices seen
  logic                  lsbMode;     // Bench view: LSB first in force
  logic                  sdoMode;     // Bench view: separate output pin in force
  dac_spi_pkg::wr_t      regWrite;    // Write notice from the port
  dac_spi_pkg::wr_t      lastWr;      // Latest write notice

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  dac_spi_register_port dac_spi_register_port_i (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .csN(csN),
    .sdioIn(sdioLine), .sdioOut(sdioOut), .sdioOeN(sdioOeN),
    .sdoOut(sdoOut), .sdoOeN(sdoOeN), .regImage(regImage),
    .portCfg(portCfg), .regWrite(regWrite)
  );

  // The notice stands for one core cycle only, so keep the latest one and count them
  always @(posedge core_clk) begin
    if (regWrite.en) begin
      lastWr  <= regWrite;
      nWrites <= nWrites + 1;
    end
  end

  link_master link_master_i (
    .core_clk(core_clk), .sclk(sclk), .csN(csN), .sdioLine(sdioLine),
    .sdoLine(sdoLine), .sdioOut(sdioOut), .sdioOeN(sdioOeN),
    .sdoOut(sdoOut), .sdoOeN(sdoOeN)
  );

  // ========================================================
  // Compare and report
  // ========================================================
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] act);
    nCompared++;
    if (act !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, act);
    end
  endtask : chk

  task automatic wrap_up();
    if (mismatches == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // One frame in the bench's own view of the port mode; e is the register
  // after a write (seen before deselect) or the readback
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      input logic [7:0] e);
    int w0;
    w0 = nWrites;
    link_master_i.sel(1'b0);
    link_master_i.shift(8, {rd, a}, lsbMode, 1'b0, sdoMode, got);
    link_master_i.shift(8, d, lsbMode, rd, sdoMode, got);
    chk(rd ? "readback" : "written", e, rd ? got : regImage[a]);
    chk("notice count", rd ? 8'h00 : 8'h01, 8'(nWrites - w0));
    if (!rd) begin
      chk("notice addr", {1'b0, a}, {1'b0, lastWr.addr});
      chk("notice data", d, lastWr.data);
    end
    // A configuration write changes the mode from the next frame on
    if (!rd && a == dac_spi_pkg::CFG_ADDR) begin
      lsbMode = e[dac_spi_pkg::CFG_LSB_BIT];
      sdoMode = !e[dac_spi_pkg::CFG_BIDIR_BIT];
    end
    link_master_i.sel(1'b1);
    chk("enables off", 8'h03, {6'h00, sdioOeN, sdoOeN});
  endtask : xfer

  // ========================================================
  // Scenarios
  // ========================================================
  task automatic sc_basic();
    chk("cfg reset", 8'h80, regImage[0]);
    xfer(1'b0, 7'h05, 8'ha5, 8'ha5);
    xfer(1'b1, 7'h05, 8'h00, 8'ha5);
    chk("neighbour", 8'h00, regImage[4]);
  endtask : sc_basic

  // Walking address bits plus the top register
  task automatic sc_all();
    logic [6:0] a;
    for (int k = 0; k < 8; k++) begin
      a = (k < 7) ? 7'(1 << k) : 7'h7f;
      xfer(1'b0, a, {1'b1, a} ^ 8'h5a, {1'b1, a} ^ 8'h5a);
      xfer(1'b1, a, 8'h00, {1'b1, a} ^ 8'h5a);
    end
  endtask : sc_all

  // Stall at a byte boundary, then abort in mid-byte
  task automatic sc_stall();
    link_master_i.sel(1'b0);
    link_master_i.shift(8, 8'h30, lsbMode, 1'b0, sdoMode, got);
    link_master_i.sel(1'b1);
    link_master_i.sel(1'b0);
    link_master_i.shift(8, 8'h96, lsbMode, 1'b0, sdoMode, got);
    link_master_i.sel(1'b1);
    chk("stalled write", 8'h96, regImage[48]);
    link_master_i.sel(1'b0);
    link_master_i.shift(8, 8'h31, lsbMode, 1'b0, sdoMode, got);
    link_master_i.shift(4, 8'hff, lsbMode, 1'b0, sdoMode, got);
    link_master_i.sel(1'b1);
    xfer(1'b0, 7'h32, 8'h77, 8'h77);
    chk("aborted write", 8'h00, regImage[49]);
  endtask : sc_stall

  // Separate pins, then least significant bit first
  task automatic sc_modes();
    xfer(1'b0, 7'h00, 8'h00, 8'h00);
    chk("pin mode", 8'h00, portCfg);
    xfer(1'b1, 7'h05, 8'h00, 8'ha5);
    chk("read is passive", 8'ha5, regImage[5]);
    xfer(1'b0, 7'h00, 8'h40, 8'h40);
    chk("order mode", 8'h40, portCfg);
    xfer(1'b0, 7'h22, 8'h1d, 8'h1d);
    xfer(1'b1, 7'h22, 8'h00, 8'h1d);
  endtask : sc_modes

  // Zero-run recovery, then default restore
  task automatic sc_recover();
    link_master_i.sel(1'b0);
    link_master_i.shift(3, 8'h00, lsbMode, 1'b0, sdoMode, got);
    for (int k = 0; k < 3; k++) begin
      link_master_i.shift(8, 8'h00, lsbMode, 1'b0, sdoMode, got);
    end
    link_master_i.sel(1'b1);
    chk("recovered cfg", dac_spi_pkg::RECOVER_CFG, regImage[0]);
    // Recovery leaves MSB first and the separate output pin in force
    lsbMode = dac_spi_pkg::RECOVER_CFG[dac_spi_pkg::CFG_LSB_BIT];
    sdoMode = !dac_spi_pkg::RECOVER_CFG[dac_spi_pkg::CFG_BIDIR_BIT];
    xfer(1'b1, 7'h22, 8'h00, 8'h1d);
    xfer(1'b0, 7'h00, 8'ha0, 8'h80);
    chk("restored", 8'h00, regImage[34]);
    xfer(1'b1, 7'h00, 8'h00, 8'h80);
  endtask : sc_recover

  // ========================================================
  // Main sequence and watchdog
  // ========================================================
  initial begin
    rst_n = 1'b0;
    mismatches = 0;
    nCompared = 0;
    // The port leaves reset with a shared pin and MSB first
    lsbMode = dac_spi_pkg::CFG_RESET[dac_spi_pkg::CFG_LSB_BIT];
    sdoMode = !dac_spi_pkg::CFG_RESET[dac_spi_pkg::CFG_BIDIR_BIT];
    repeat (10) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    sc_basic();
    sc_all();
    sc_stall();
    sc_modes();
    sc_recover();
    wrap_up();
  end

  // A hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
